// ---- logic/watchdog_reset_timer.sv ----
// watchdog reset timer: control register, clock select, standby handling
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// [R01] clock select 0 picks the low-speed rc clock, 1 the subclock
// [R02] run bit 1 starts counting; 0 stops and holds counter cleared
// [R03] standby action: 00/11 continue, 01 stop, 10 pause keeping count
// [R04] overflow select 000 gives 1024, doubling each step to 131072
// [R05] pin or power resets zero the register; dog reset keeps bit 6, 4..0
// [R06] while running, ordinary writes are ignored; register stays readable
// [R07] running: immediate-move write of 55h clears counter to 0
// [R08] run clears only on pin/power reset, standby with action 1, or a dog reset
// [R09] running counter steps each dog clock; overflow raises the dog reset
// [R10] every dog reset sets the flag in bit 7
// [R11] rc enable when clock select 0 and run, or rc start bit set
// [R12] action 2 on rc clock: standby stops rc and freezes count
// [R13] standby re-entry within 4 rc periods may leave rc running
// [R14] subclock running: enable cleared or hold mode fires dog reset
// [R15] action 0 or 3 on rc clock keeps rc running through hold
// [R16] rc start bit keeps rc running in standby even for action 1/2
// [R17] software sets fields first, then run; fields locked once running
// [R18] software issues 55h clear before each overflow
// [R19] software enables and settles subclock before starting on it
// [R20] overflow when count reaches selected value; overflow clears run
// [R21] counter is 17-bit, clocked by the selected dog clock
// [R22] software may write the flag; pin and power resets clear it
// [R23] clock inputs synchronised; reset request registered before output
//////////////////////////////////////////////////////////////////////////////
module watchdog_reset_timer
    import watchdog_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic imm_move,
    output logic [DATA_W-1:0] rdata,
    input wire logic rc_clk,
    input wire logic sub_clk,
    input wire logic standby,
    input wire logic hold,
    output logic dog_reset,
    output logic rc_osc_en
);
    dog_count_if cif ();

    dog_counter #(.WIDTH(CNT_W)) u_counter (
        .clk(clk),
        .reset_n(reset_n),
        .cif(cif)
    );

    //////////////////////////////////////////////////////////////////////////
    // clock input synchronisers and edge detect
    logic [2:0] rc_sync_ff;
    logic [2:0] sub_sync_ff;
    logic [2:0] nxt_rc_sync;
    logic [2:0] nxt_sub_sync;
    logic rc_tick;
    logic sub_tick;

    always_comb begin
        nxt_rc_sync = {rc_sync_ff[1:0], rc_clk}; // R23
        nxt_sub_sync = {sub_sync_ff[1:0], sub_clk}; // R23
        // first stage is only read by the second
        rc_tick = rc_sync_ff[1] && !rc_sync_ff[2];
        sub_tick = sub_sync_ff[1] && !sub_sync_ff[2];
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rc_sync_ff <= 3'h0;
            sub_sync_ff <= 3'h0;
        end else begin
            rc_sync_ff <= nxt_rc_sync;
            sub_sync_ff <= nxt_sub_sync;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // control decode
    logic [DATA_W-1:0] ctl_ff;
    logic rc_start_ff;
    logic sub_en_ff;
    logic cksel;
    logic run;
    standby_action_t act;
    logic wr_ctl;
    logic clear_cmd;
    logic standby_stop;
    logic paused;
    logic sub_fail;
    logic fire;
    logic sel_tick;

    always_comb begin
        cksel = ctl_ff[BIT_CKSEL];
        run = ctl_ff[BIT_RUN];
        act = standby_action_t'(ctl_ff[BIT_ACT_HI:BIT_ACT_LO]);
        wr_ctl = wr_stb && (addr == ADDR_CONTROL);
        clear_cmd = wr_ctl && run && imm_move && (wdata == CLEAR_CODE); // R07
        sel_tick = cksel ? sub_tick : rc_tick; // R01
        standby_stop = run && standby && (act == ACT_STOP); // R08
        paused = standby && (act == ACT_PAUSE); // R03 R12
        sub_fail = run && cksel && (!sub_en_ff || hold); // R14
        fire = run && (cif.ovf || sub_fail); // R09
        cif.sel = ctl_ff[BIT_SEL_HI:BIT_SEL_LO]; // R04
        cif.tick = run && !paused && !standby_stop && sel_tick; // R21
        cif.clear = !run || clear_cmd || fire || standby_stop; // R02
    end

    //////////////////////////////////////////////////////////////////////////
    // registers
    logic [DATA_W-1:0] nxt_ctl;
    logic nxt_rc_start;
    logic nxt_sub_en;
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;
    logic dog_reset_ff;
    logic nxt_dog_reset;

    always_comb begin
        nxt_ctl = ctl_ff;
        if (wr_ctl && !run) begin
            nxt_ctl = wdata; // R22
        end
        // locked while running; the 55h command only touches the counter
        if (standby_stop) begin
            nxt_ctl[BIT_RUN] = 1'b0; // R08
        end
        // the dog's own reset keeps clock select and bits 4..0
        if (fire) begin
            nxt_ctl[BIT_RUN] = 1'b0; // R20
            nxt_ctl[BIT_FLAG] = 1'b1; // R10 R05
        end
        nxt_rc_start = rc_start_ff;
        nxt_sub_en = sub_en_ff;
        if (wr_stb && addr == ADDR_RC_CTL) begin
            nxt_rc_start = wdata[BIT_RC_START];
        end
        if (wr_stb && addr == ADDR_OSC_CTL) begin
            nxt_sub_en = wdata[BIT_SUB_EN];
        end
        nxt_rdata = READ_NONE;
        if (rd_stb) begin
            case (addr)
                ADDR_CONTROL: nxt_rdata = ctl_ff; // R06
                ADDR_RC_CTL: nxt_rdata[BIT_RC_START] = rc_start_ff;
                ADDR_OSC_CTL: nxt_rdata[BIT_SUB_EN] = sub_en_ff;
                default: nxt_rdata = READ_NONE;
            endcase
        end
        nxt_dog_reset = fire; // R23
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctl_ff <= CTL_RESET; // R05
            rc_start_ff <= 1'b0;
            sub_en_ff <= 1'b0;
            rdata_ff <= READ_NONE;
            dog_reset_ff <= 1'b0;
        end else begin
            ctl_ff <= nxt_ctl;
            rc_start_ff <= nxt_rc_start;
            sub_en_ff <= nxt_sub_en;
            rdata_ff <= nxt_rdata;
            dog_reset_ff <= nxt_dog_reset;
        end
    end

    assign rdata = rdata_ff;
    assign dog_reset = dog_reset_ff;

    //////////////////////////////////////////////////////////////////////////
    // rc oscillator enable with re-entry guard
    logic [2:0] guard_ff;
    logic [2:0] nxt_guard;
    logic standby_d_ff;
    logic stuck_ff;
    logic nxt_stuck;
    logic rc_en_ff;
    logic nxt_rc_en;
    logic rc_may_stop;
    logic early_entry;

    always_comb begin
        nxt_guard = guard_ff;
        if (standby_d_ff && !standby) begin
            nxt_guard = 3'h0;
        end else if (!standby && rc_tick && guard_ff < RC_GUARD_TICKS) begin
            nxt_guard = guard_ff + 3'h1;
        end
        // a too-early re-entry leaves the oscillator on for that standby
        nxt_stuck = stuck_ff;
        if (standby && !standby_d_ff) begin
            nxt_stuck = (guard_ff < RC_GUARD_TICKS); // R13
        end else if (!standby) begin
            nxt_stuck = 1'b0;
        end
        // decided on the entry edge itself, so the enable never blinks off
        early_entry = standby_d_ff ? stuck_ff : (guard_ff < RC_GUARD_TICKS); // R13
        rc_may_stop = standby && !early_entry && (act == ACT_STOP || act == ACT_PAUSE); // R12
        // actions 0 and 3 never stop it, hold included
        nxt_rc_en = (!cksel && run && !rc_may_stop) || rc_start_ff; // R11 R15 R16
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            guard_ff <= RC_GUARD_TICKS;
            standby_d_ff <= 1'b0;
            stuck_ff <= 1'b0;
            rc_en_ff <= 1'b0;
        end else begin
            guard_ff <= nxt_guard;
            standby_d_ff <= standby;
            stuck_ff <= nxt_stuck;
            rc_en_ff <= nxt_rc_en;
        end
    end

    assign rc_osc_en = rc_en_ff;

    //////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_fire_out;
        dog_reset && ctl_ff[BIT_FLAG] && !ctl_ff[BIT_RUN];
    endsequence

    sequence s_cleared_stay;
        cif.count == '0 ##1 cif.count <= 1;
    endsequence

    AST_LOCKED: assert property (run && wr_ctl && !fire && !standby_stop |=> // R06
        ctl_ff == $past(ctl_ff))
        else $error("control changed by a write while running");
    AST_STOP_HOLDS_ZERO: assert property (!run ##1 !run |-> cif.count == '0) // R02
        else $error("counter not cleared while stopped");
    AST_FIRE_FLAG: assert property (fire |=> s_fire_out) // R10
        else $error("fire without reset pulse and flag");
    AST_CLEAR_CMD: assert property (clear_cmd |=> s_cleared_stay) // R07
        else $error("55h command did not clear the counter");
    AST_PLAIN_55: assert property (wr_ctl && run && !imm_move && !fire && !standby_stop
        && !paused && !sel_tick |=> cif.count == $past(cif.count)) // R07
        else $error("non-immediate 55h touched the counter");
    AST_RC_ENABLE: assert property (!cksel && run && !standby |=> rc_osc_en) // R11
        else $error("rc oscillator off while selected and running");
    AST_RC_START: assert property (rc_start_ff |=> rc_osc_en) // R16
        else $error("rc start bit did not keep oscillator on");
    AST_SUB_FAIL: assert property (run && cksel && hold |=> dog_reset) // R14
        else $error("hold on subclock did not fire");
    AST_STANDBY_STOP: assert property (standby_stop |=> !run ##1 cif.count == '0) // R08
        else $error("standby stop did not clear run");
    AST_PAUSE_HOLDS: assert property (run && paused && !fire && !wr_ctl |=> // R12
        cif.count == $past(cif.count))
        else $error("count moved while paused");
    AST_RESET_KEEPS: assert property (fire |=> // R05
        ctl_ff[BIT_CKSEL] == $past(ctl_ff[BIT_CKSEL])
        && ctl_ff[BIT_ACT_HI:BIT_SEL_LO] == $past(ctl_ff[BIT_ACT_HI:BIT_SEL_LO]))
        else $error("dog reset changed kept fields");
    AST_READ_BACK: assert property (rd_stb && addr == ADDR_CONTROL && !fire && !wr_ctl
        |=> rdata == $past(ctl_ff)) // R06
        else $error("control read back wrong");
    AST_RDATA_IDLE: assert property (!rd_stb |=> rdata == READ_NONE) // R06
        else $error("read data left standing");

    // reset pulse, flag, stopped write, clock source and oscillator checks
    sequence s_pulse_once;
        dog_reset ##1 !dog_reset;
    endsequence

    // one-cycle request: the run bit is already down when it leaves
    AST_PULSE_ONCE: assert property (fire |=> s_pulse_once) // R09
        else $error("dog reset not a single pulse");
    AST_SUB_OSC_OFF: assert property (run && cksel && !sub_en_ff |=> // R14
        dog_reset && ctl_ff[BIT_FLAG])
        else $error("subclock enable cleared without dog reset");
    AST_FLAG_STICKY: assert property (ctl_ff[BIT_FLAG] && !wr_ctl |=> ctl_ff[BIT_FLAG]) // R10
        else $error("flag dropped without a write");
    AST_STOPPED_WRITE: assert property (wr_ctl && !run |=> ctl_ff == $past(wdata)) // R22
        else $error("write while stopped did not land");
    AST_SUB_IGNORES_RC: assert property (run && cksel && !sub_tick && !fire // R01
        && !clear_cmd && !standby_stop |=> cif.count == $past(cif.count))
        else $error("count moved without a subclock tick");
    AST_RC_IGNORES_SUB: assert property (run && !cksel && !rc_tick && !fire // R01
        && !clear_cmd && !standby_stop |=> cif.count == $past(cif.count))
        else $error("count moved without an rc tick");
    AST_RC_HOLD_ON: assert property (!cksel && run && standby // R15
        && (act == ACT_CONTINUE || act == ACT_CONTINUE_ALT) |=> rc_osc_en)
        else $error("rc oscillator stopped under a continue action");
    AST_RC_PAUSE_OFF: assert property (standby && standby_d_ff && !stuck_ff // R12
        && act == ACT_PAUSE && !rc_start_ff |=> !rc_osc_en)
        else $error("rc oscillator kept running in a paused standby");
    AST_EARLY_REENTRY: assert property (standby && !standby_d_ff && !cksel && run // R13
        && guard_ff < RC_GUARD_TICKS |=> rc_osc_en)
        else $error("rc oscillator stopped on an early standby re-entry");
endmodule

// ---- include/watchdog_pkg.sv ----
// package: register map, field positions and helpers for the watchdog
package watchdog_pkg;
    localparam int CNT_W = 17;
    localparam int SEL_W = 3;
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;
    localparam int LIMIT_W = CNT_W + 1;

    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_RC_CTL = 2'h1;
    localparam logic [ADDR_W-1:0] ADDR_OSC_CTL = 2'h2;

    localparam int BIT_FLAG = 7;
    localparam int BIT_CKSEL = 6;
    localparam int BIT_RUN = 5;
    localparam int BIT_ACT_HI = 4;
    localparam int BIT_ACT_LO = 3;
    localparam int BIT_SEL_HI = 2;
    localparam int BIT_SEL_LO = 0;
    localparam int BIT_RC_START = 0;
    localparam int BIT_SUB_EN = 6;

    localparam logic [DATA_W-1:0] CTL_RESET = 8'h00;
    localparam logic [DATA_W-1:0] CLEAR_CODE = 8'h55;
    localparam logic [DATA_W-1:0] READ_NONE = 8'h00;
    localparam logic [LIMIT_W-1:0] BASE_COUNT = 18'h00400;
    localparam logic [2:0] RC_GUARD_TICKS = 3'h4;

    typedef enum logic [1:0] {
        ACT_CONTINUE,
        ACT_STOP,
        ACT_PAUSE,
        ACT_CONTINUE_ALT
    } standby_action_t;

    function automatic logic [LIMIT_W-1:0] overflow_limit(input logic [SEL_W-1:0] sel);
        return BASE_COUNT << sel;
    endfunction
endpackage

// ---- include/dog_count_if.sv ----
// interface: control and status between the watchdog core and its counter
`timescale 1ns/1ps
interface dog_count_if;
    import watchdog_pkg::*;
    logic tick;
    logic clear;
    logic [SEL_W-1:0] sel;
    logic [CNT_W-1:0] count;
    logic ovf;
    modport ctrl (output tick, output clear, output sel, input count, input ovf);
    modport cnt (input tick, input clear, input sel, output count, output ovf);
endinterface

// ---- logic/dog_counter.sv ----
// up-counter with selectable overflow count
`timescale 1ns/1ps
module dog_counter
    import watchdog_pkg::*;
#(
    parameter int WIDTH = CNT_W
) (
    input wire logic clk,
    input wire logic reset_n,
    dog_count_if.cnt cif
);
    logic [WIDTH-1:0] count_ff;
    logic [WIDTH-1:0] nxt_count;
    logic [WIDTH:0] next_val;

    // widened by one bit so the top limit, one past the counter range, can match
    always_comb begin
        next_val = {1'b0, count_ff} + {{WIDTH{1'b0}}, 1'b1};
        cif.ovf = cif.tick && (next_val == overflow_limit(cif.sel)); // R20
        nxt_count = count_ff;
        if (cif.clear) begin
            nxt_count = '0;
        end else if (cif.tick) begin
            nxt_count = next_val[WIDTH-1:0]; // R21
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end

    assign cif.count = count_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_CNT_STEP: assert property (cif.tick && !cif.clear |=> // R21
        count_ff == $past(count_ff) + 1'b1)
        else $error("counter did not step on tick");
    AST_OVF_AT_LIMIT: assert property (cif.ovf |-> // R04
        {1'b0, count_ff} + 1'b1 == (BASE_COUNT << cif.sel))
        else $error("overflow away from selected count");
endmodule

// ---- bench/testbench.sv ----
// self-checking bench for the watchdog reset timer
`timescale 1ns/1ps
module testbench;
    import watchdog_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic imm_move = 1'b0;
    logic rc_clk = 1'b0;
    logic sub_clk = 1'b0;
    logic standby = 1'b0;
    logic hold = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic dog_reset;
    logic rc_osc_en;
    logic rd_q = 1'b0;
    logic [DATA_W-1:0] exp_q[$];
    int err_total = 0;
    int n_tests = 0;
    int pulses = 0;
    int cycles = 0;
    int cyc;
    logic [DATA_W-1:0] v;

    watchdog_reset_timer watchdog_reset_timer_i (.clk(clk), .reset_n(reset_n), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .imm_move(imm_move), .rdata(rdata),
        .rc_clk(rc_clk), .sub_clk(sub_clk), .standby(standby), .hold(hold),
        .dog_reset(dog_reset), .rc_osc_en(rc_osc_en));

    always #50 clk = ~clk;

    // dog clocks kept well below clk so the synchronisers see every edge
    always begin
        repeat (4) @(posedge clk);
        rc_clk <= ~rc_clk;
    end
    always begin
        repeat (5) @(posedge clk);
        sub_clk <= ~sub_clk;
    end

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_q) begin
            if (exp_q.size() == 0) begin
                check("read_queue", 32'h1, 32'h0);
            end else begin
                check("rdata", {24'h0, rdata}, {24'h0, exp_q.pop_front()});
            end
        end
        rd_q <= rd_stb;
        if (dog_reset === 1'b1) begin
            pulses++;
        end
        cycles++;
        if (cycles == 90000) begin
            err_total++;
            tally_and_finish();
        end
    end

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic imm);
        @(posedge clk);
        wr_stb <= 1'b1;
        addr <= a;
        wdata <= d;
        imm_move <= imm;
        @(posedge clk);
        wr_stb <= 1'b0;
        imm_move <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge clk);
        rd_stb <= 1'b1;
        addr <= a;
        exp_q.push_back(e);
        @(posedge clk);
        rd_stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_pulse(input int max, output int n);
        int p0;
        p0 = pulses;
        n = 0;
        while (pulses == p0 && n < max) begin
            @(posedge clk);
            n++;
        end
    endtask

    initial begin
        void'($urandom(32'h2581c739));
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        rd(ADDR_CONTROL, CTL_RESET);
        rd(ADDR_RC_CTL, 8'h00);
        rd(ADDR_OSC_CTL, 8'h00);
        rd(2'h3, READ_NONE);
        #1 check("rc_osc_en_rst", rc_osc_en, 1'b0);
        $display("test reset_values done");

        repeat (6) begin
            v = DATA_W'($urandom()) & 8'hdf;
            wr(ADDR_CONTROL, v, 1'b0);
            rd(ADDR_CONTROL, v);
        end
        wr(2'h3, 8'hff, 1'b0);
        rd(2'h3, READ_NONE);
        wr(ADDR_RC_CTL, 8'h01, 1'b0);
        repeat (2) @(posedge clk);
        #1 check("rc_osc_en_start", rc_osc_en, 1'b1);
        rd(ADDR_RC_CTL, 8'h01);
        wr(ADDR_RC_CTL, 8'h00, 1'b0);
        $display("test register_access done");

        for (int s = 0; s < 2; s++) begin
            wr(ADDR_CONTROL, 8'h00, 1'b0);
            wr(ADDR_CONTROL, 8'h20 | 8'(s), 1'b0);
            wait_pulse(4, cyc);
            #1 check("rc_osc_en_run", rc_osc_en, 1'b1);
            wr(ADDR_CONTROL, 8'h00, 1'b0);
            wr(ADDR_CONTROL, CLEAR_CODE, 1'b0);
            wait_pulse(20000, cyc);
            // tick every 8 clk; sync and phase slop allowed
            check("ovf_time", 32'(cyc + 16 > (1024 << s) * 8 - 24), 32'h1);
            check("ovf_late", 32'(cyc + 16 < (1024 << s) * 8 + 24), 32'h1);
            rd(ADDR_CONTROL, 8'h80 | 8'(s));
        end
        $display("test overflow done");

        wr(ADDR_CONTROL, 8'h00, 1'b0);
        wr(ADDR_CONTROL, 8'h20, 1'b0);
        wait_pulse(7000, cyc);
        check("early_reset", cyc, 7000);
        wr(ADDR_CONTROL, CLEAR_CODE, 1'b1);
        // continue action keeps counting and the rc clock through hold
        standby <= 1'b1;
        hold <= 1'b1;
        wait_pulse(7000, cyc);
        check("cleared_count", cyc, 7000);
        #1 check("rc_on_hold", rc_osc_en, 1'b1);
        @(posedge clk);
        standby <= 1'b0;
        hold <= 1'b0;
        wait_pulse(2000, cyc);
        check("ovf_after_clear", 32'(cyc < 1300), 32'h1);
        rd(ADDR_CONTROL, 8'h80);
        $display("test clear_command done");

        wr(ADDR_CONTROL, 8'h00, 1'b0);
        wr(ADDR_CONTROL, 8'h30, 1'b0);
        wait_pulse(4000, cyc);
        check("pause_early", cyc, 4000);
        standby <= 1'b1;
        repeat (4) @(posedge clk);
        #1 check("rc_off_pause", rc_osc_en, 1'b0);
        wr(ADDR_RC_CTL, 8'h01, 1'b0);
        repeat (2) @(posedge clk);
        #1 check("rc_start_standby", rc_osc_en, 1'b1);
        wr(ADDR_RC_CTL, 8'h00, 1'b0);
        wait_pulse(6000, cyc);
        check("paused_count", cyc, 6000);
        // re-enter after two cycles, well inside the guard time
        standby <= 1'b0;
        repeat (2) @(posedge clk);
        standby <= 1'b1;
        repeat (3) @(posedge clk);
        #1 check("rc_early_entry", rc_osc_en, 1'b1);
        @(posedge clk);
        standby <= 1'b0;
        wait_pulse(5000, cyc);
        // about 500 of 1024 ticks were counted when the pause began
        check("resume_time", 32'(cyc > 4100 && cyc < 4300), 32'h1);
        rd(ADDR_CONTROL, 8'h90);
        $display("test standby_pause done");

        for (int h = 0; h < 2; h++) begin
            wr(ADDR_CONTROL, 8'h00, 1'b0);
            wr(ADDR_OSC_CTL, 8'h40, 1'b0);
            wr(ADDR_CONTROL, 8'h60, 1'b0);
            wait_pulse(30, cyc);
            check("sub_running", cyc, 30);
            if (h == 0) begin
                wr(ADDR_OSC_CTL, 8'h00, 1'b0);
            end else begin
                standby <= 1'b1;
                hold <= 1'b1;
            end
            wait_pulse(6, cyc);
            check("sub_fail_reset", 32'(cyc < 6), 32'h1);
            standby <= 1'b0;
            hold <= 1'b0;
            rd(ADDR_CONTROL, 8'hc0);
        end
        $display("test subclock_fail done");

        wr(ADDR_CONTROL, 8'h00, 1'b0);
        wr(ADDR_CONTROL, 8'h28, 1'b0);
        standby <= 1'b1;
        repeat (4) @(posedge clk);
        #1 check("rc_off_standby", rc_osc_en, 1'b0);
        @(posedge clk);
        standby <= 1'b0;
        rd(ADDR_CONTROL, 8'h08);
        wr(ADDR_CONTROL, 8'h1f, 1'b0);
        rd(ADDR_CONTROL, 8'h1f);
        $display("test standby_stop done");

        wr(ADDR_CONTROL, 8'h9f, 1'b0);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd(ADDR_CONTROL, CTL_RESET);
        $display("test pin_reset done");
        repeat (3) @(posedge clk);
        tally_and_finish();
    end
endmodule
